// File: rtl/rtseq_consts.svh
`ifndef RTSEQ_CONSTS_SVH
`define RTSEQ_CONSTS_SVH
// ----------------------------------------
// register map (byte addresses, apb)
// ----------------------------------------
`define RTSEQ_ADDR_CAUSE    12'h000
`define RTSEQ_ADDR_STATUS   12'h004
`define RTSEQ_ADDR_CONFIG   12'h008
`define RTSEQ_ADDR_CTRL     12'h00c
// ----------------------------------------
// field positions
// ----------------------------------------
`define RTSEQ_CAUSE_BOR_BIT 0
`define RTSEQ_CAUSE_POR_BIT 1
`define RTSEQ_ST_PD_BIT     0
`define RTSEQ_ST_TO_BIT     1
`define RTSEQ_ST_RST_BIT    2
`define RTSEQ_ST_SLEEP_BIT  3
`define RTSEQ_CFG_OSC_LSB   0
`define RTSEQ_CFG_PWRTN_BIT 3
`define RTSEQ_CFG_BROWNOUT_EN_BIT 4
`define RTSEQ_CFG_PINSEL_BIT 5
`define RTSEQ_CTRL_SLEEP_BIT 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define RTSEQ_CFG_RESET     6'h3f
// ----------------------------------------
// timing (clock 125 mhz)
// ----------------------------------------
`define RTSEQ_CLK_MHZ       125
`define RTSEQ_POWERUP_TIMER_MS       72
`define RTSEQ_POWERUP_TIMER_CYC      (`RTSEQ_POWERUP_TIMER_MS * 1000 * `RTSEQ_CLK_MHZ)
`define RTSEQ_OST_CYC       1024
`define RTSEQ_CPU_NS        5000
`define RTSEQ_CPU_CYC       ((`RTSEQ_CPU_NS * `RTSEQ_CLK_MHZ + 999) / 1000)
`define RTSEQ_BOR_US        100
`define RTSEQ_BOR_CYC       (`RTSEQ_BOR_US * `RTSEQ_CLK_MHZ)
`define RTSEQ_GLITCH_NS     64
`define RTSEQ_GLITCH_CYC    ((`RTSEQ_GLITCH_NS * `RTSEQ_CLK_MHZ + 999) / 1000)
`endif

// File: rtl/rtseq_pkg.sv
package rtseq_pkg;
   // oscillator select codes
   typedef enum logic [2:0] {
      lowpower_crystal_mode  = 3'h0,
      std_crystal_mode       = 3'h1,
      highspeed_crystal_mode = 3'h2,
      external_clock_in      = 3'h3,
      internal_rc_osc        = 3'h4,
      internal_rc_osc_clko   = 3'h5,
      external_rc_osc        = 3'h6,
      external_rc_osc_clko   = 3'h7
   } rtseq_osc_t;
   // apb request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rtseq_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } rtseq_apb_rsp_t;
   // supply/pin raw events
   typedef struct packed {
      logic por_n;        // low while supply ramps
      logic below_bor;    // supply under brownout_threshold
      logic ext_reset_n;  // shared reset pin
      logic watchdog_to;  // watchdog time-out pulse
      logic irq_wake;     // interrupt wake request
   } rtseq_src_t;
   // sequencer states
   typedef enum logic [4:0] {
      st_hold = 5'b00001,
      st_powerup_timer = 5'b00010,
      st_ost  = 5'b00100,
      st_run  = 5'b01000,
      st_slp  = 5'b10000
   } rtseq_state_t;
endpackage

// File: rtl/rtseq_top.sv
// Behaviour
// - distinguish power-on, pin run/sleep, watchdog run, watchdog wake, brown-out causes
// - untouched-class registers keep value across every non-power-on reset
// - general reset on por/pin/watchdog/brown-out; watchdog wake resumes
// - cpu start-up delay after power-on, brown-out or wake, concurrent
// - reset pin filter rejects short glitches
// - watchdog reset never drives the reset pin
// - select bit picks reset pin (default) or general i/o
// - power-up timer of 72 ms holds device in reset
// - power-up timer runs only when its enable bit is zero
// - 1024-cycle oscillator count after power-up timer, then release
// - oscillator count only crystal modes, only power-on or wake
// - non-crystal modes use power-up timer or cpu delay only
// - brown-out resets after dip longer than 100 us when enabled
// - brown-out holds until recovery then timer; new dip restarts
// - brown-out enable and power-up timer enable are independent
// - cause bit 0 cleared by brown-out, set by software
// - cause bit 1 cleared by power-on only, set by software
// - flags: por sets both; brown-out sets both; watchdog clears timeout
// - watchdog wake clears both; sleep pin/irq wake sets timeout only
// - i/o mode treats internal reset pin as deasserted
// - brown-out enable is active high
// - codes 000, 001 and high-speed code enable oscillator count
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rtseq_consts.svh"
module rtseq_top #(
   parameter int unsigned POWERUP_TIMER_CYC = `RTSEQ_POWERUP_TIMER_CYC,
   parameter int unsigned BOR_CYC  = `RTSEQ_BOR_CYC
) (
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    clk_en,
   // apb slave
   input  wire rtseq_pkg::rtseq_apb_req_t apb_req,
   output var  rtseq_pkg::rtseq_apb_rsp_t apb_rsp,
   // raw sources from pins and detectors
   input  wire rtseq_pkg::rtseq_src_t   src,
   input  wire logic                    osc_input,
   // reset pin as general i/o
   output logic                         pin_io_in,
   output logic                         pin_drive_oe,
   // core side
   output logic                         core_reset_n,
   output logic                         core_sleeping
);
   import rtseq_pkg::*;

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [4:0] meta_q, sync_q;
   logic       osc_m_q, osc_s_q, osc_p_q;

   // async sources all pass two flops before use
   // flops reset to the idle level of each source, so releasing
   // presetn never looks like a pin, watchdog or wake event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 5'h1f;
         sync_q <= 5'h1f;
      end else if (clk_en) begin
         meta_q <= {src.por_n, ~src.below_bor, src.ext_reset_n, ~src.watchdog_to, ~src.irq_wake};
         sync_q <= meta_q;
      end
   end

   // oscillator input sampled; edge taken only from second flop onward
   // limitation: osc_input must stay below half the pclk rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_m_q <= 1'b0;
         osc_s_q <= 1'b0;
         osc_p_q <= 1'b0;
      end else if (clk_en) begin
         osc_m_q <= osc_input;
         osc_s_q <= osc_m_q;
         osc_p_q <= osc_s_q;
      end
   end

   // synchronised levels, named by what they mean when high
   logic por_n_s, bor_ok_s, pin_s, wdt_s, irq_s, osc_rise;
   assign por_n_s  = sync_q[4];
   assign bor_ok_s = sync_q[3];
   assign pin_s    = sync_q[2];
   assign wdt_s    = ~sync_q[1];
   assign irq_s    = ~sync_q[0];
   assign osc_rise = osc_s_q & ~osc_p_q;

   // ----------------------------------------
   // configuration and control registers
   // ----------------------------------------
   logic [5:0] cfg_q;
   logic       sleep_req_q;
   logic [1:0] cause_q;
   logic       to_q, pd_q;
   logic       wr_en, rd_en;

   // reads decode without penable; prdata only matters in access
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_en = apb_req.psel & ~apb_req.pwrite;


   // configuration fields; the two enables act independently
   rtseq_osc_t osc_mode;
   logic       powerup_timer_on, bor_en, pin_sel, crystal;
   assign osc_mode = rtseq_osc_t'(cfg_q[`RTSEQ_CFG_OSC_LSB +: 3]);
   assign powerup_timer_on  = ~cfg_q[`RTSEQ_CFG_PWRTN_BIT];
   assign bor_en   = cfg_q[`RTSEQ_CFG_BROWNOUT_EN_BIT];
   assign pin_sel  = cfg_q[`RTSEQ_CFG_PINSEL_BIT];
   assign crystal  = (osc_mode == lowpower_crystal_mode) ||
                     (osc_mode == std_crystal_mode) ||
                     (osc_mode == highspeed_crystal_mode);

   // config survives every reset but the apb reset (power-on domain)
   // limitation: a mode change takes effect at once, even mid-sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg_q <= `RTSEQ_CFG_RESET;
      else if (clk_en && wr_en && apb_req.paddr == `RTSEQ_ADDR_CONFIG)
         cfg_q <= apb_req.pwdata[5:0];
   end

   // ----------------------------------------
   // pin filter and brown-out qualifier
   // ----------------------------------------
   logic [7:0]  glitch_q;
   logic        pin_low_q;
   logic        pin_asserted;
   // i/o mode: internal reset input held high
   // pin_sel high is reset mode, the default
   assign pin_asserted = pin_sel & ~pin_s;
   // low must persist a minimum time before it counts
   // trade-off: length fixed in pclk cycles, so it scales with the clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glitch_q  <= 8'h00;
         pin_low_q <= 1'b0;
      end else if (clk_en) begin
         if (!pin_asserted) begin
            glitch_q  <= 8'h00;
            pin_low_q <= 1'b0;
         end else if (glitch_q == 8'(`RTSEQ_GLITCH_CYC)) begin
            pin_low_q <= 1'b1;
         end else begin
            glitch_q <= glitch_q + 8'h01;
         end
      end
   end

   // pin is input only: never driven, watchdog included
   assign pin_drive_oe = 1'b0;
   assign pin_io_in    = pin_sel ? 1'b1 : pin_s;


   logic [31:0] bor_cnt_q;
   logic        bor_hit_q;
   // dips shorter than the minimum time are ignored
   // the hit flag stays set until the supply is back above threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bor_cnt_q <= 32'h0;
         bor_hit_q <= 1'b0;
      end else if (clk_en) begin
         if (!bor_en || bor_ok_s) begin
            bor_cnt_q <= 32'h0;
            bor_hit_q <= 1'b0;
         end else if (bor_cnt_q >= BOR_CYC) begin
            bor_hit_q <= 1'b1;
         end else begin
            bor_cnt_q <= bor_cnt_q + 32'h1;
         end
      end
   end

   // ----------------------------------------
   // time-out sequencer
   // ----------------------------------------
   rtseq_state_t st_q;
   logic [31:0]  powerup_timer_q;
   logic [10:0]  ost_q;
   logic [9:0]   cpu_q;
   logic         ost_need_q;
   logic         hold_src;

   // the raw brown-out level holds only outside run and sleep;
   // there a dip must first qualify through bor_hit_q
   assign hold_src = ~por_n_s | bor_hit_q | (bor_en & ~bor_ok_s & st_q != st_run
                     & st_q != st_slp);

   // reset and wake events; watchdog, pin and interrupt ones tied to the state they are legal in
   logic wdt_run, wdt_wake, pin_run, pin_slp, irq_wake_ev, bor_ev, por_ev;
   assign por_ev      = ~por_n_s;
   assign bor_ev      = bor_hit_q & por_n_s;
   assign wdt_run     = wdt_s & (st_q == st_run);
   assign wdt_wake    = wdt_s & (st_q == st_slp);
   assign pin_run     = pin_low_q & (st_q == st_run);
   assign pin_slp     = pin_low_q & (st_q == st_slp);
   assign irq_wake_ev = irq_s & (st_q == st_slp) & ~pin_low_q & ~wdt_s;

   // main sequence; pin/wdt resets skip timers, wake resumes through ost/cpu
   // cpu delay counts in every state, so it overlaps the other timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= st_hold;
         powerup_timer_q     <= 32'h0;
         ost_q      <= 11'h0;
         cpu_q      <= 10'(`RTSEQ_CPU_CYC);
         ost_need_q <= 1'b1;
      end else if (clk_en) begin
         if (cpu_q != 10'h0)
            cpu_q <= cpu_q - 10'h1;
         case (st_q)
            // held while power-on or brown-out is active
            st_hold: begin
               if (hold_src) begin
                  // new dip restarts the whole sequence
                  st_q   <= st_hold;
                  powerup_timer_q <= 32'h0;
                  ost_q  <= 11'h0;
                  cpu_q  <= 10'(`RTSEQ_CPU_CYC);
                  if (por_ev)
                     ost_need_q <= 1'b1;
               end else if (powerup_timer_on)
                  st_q <= st_powerup_timer;
               else
                  st_q <= st_ost;
            end
            // power-up timer, entered only when enabled
            st_powerup_timer: begin
               if (hold_src)
                  st_q <= st_hold;
               else if (powerup_timer_q >= POWERUP_TIMER_CYC - 1)
                  st_q <= st_ost;
               else
                  powerup_timer_q <= powerup_timer_q + 32'h1;
            end
            // start-up count, crystal modes after power-on or wake
            st_ost: begin
               if (hold_src)
                  st_q <= st_hold;
               else if (!(crystal && ost_need_q) || ost_q == 11'(`RTSEQ_OST_CYC)) begin
                  st_q       <= st_run;
                  ost_need_q <= 1'b0;
               end else if (osc_rise)
                  ost_q <= ost_q + 11'h1;
            end
            // pin and watchdog resets hold the core in place
            st_run: begin
               if (hold_src || bor_ev) begin
                  st_q <= st_hold;
               end else if (sleep_req_q)
                  st_q <= st_slp;
               else if (wdt_run || pin_run)
                  st_q <= st_run;
            end
            // every wake reloads the cpu delay and re-arms the start-up count
            st_slp: begin
               if (hold_src || bor_ev)
                  st_q <= st_hold;
               else if (wdt_wake || irq_wake_ev || pin_slp) begin
                  st_q       <= st_ost;
                  ost_q      <= 11'h0;
                  ost_need_q <= 1'b1;
                  cpu_q      <= 10'(`RTSEQ_CPU_CYC);
               end
            end
            default: st_q <= st_hold;
         endcase
      end
   end


   // core held while source, timers, pin or cpu delay pending
   // registered so the core sees a clean release on a pclk edge
   logic core_rst_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         core_rst_q <= 1'b1;
      else if (clk_en)
         core_rst_q <= (st_q != st_run && st_q != st_slp) || pin_low_q ||
                       wdt_run || cpu_q != 10'h0;
   end
   assign core_reset_n  = ~core_rst_q;
   assign core_sleeping = (st_q == st_slp);


   // sleep request from software, cleared once the sequencer leaves run (entering sleep or hold) or on apb reset
   // a write outside run is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sleep_req_q <= 1'b0;
      else if (clk_en) begin
         if (st_q != st_run)
            sleep_req_q <= 1'b0;
         else if (wr_en && apb_req.paddr == `RTSEQ_ADDR_CTRL)
            sleep_req_q <= apb_req.pwdata[`RTSEQ_CTRL_SLEEP_BIT];
      end
   end

   // ----------------------------------------
   // cause bits and status flags
   // ----------------------------------------
   // hardware clears win over a same-cycle software set,
   // so a reset that lands during the write is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cause_q <= 2'b00;
      else if (clk_en) begin
         if (wr_en && apb_req.paddr == `RTSEQ_ADDR_CAUSE)
            cause_q <= apb_req.pwdata[1:0];
         if (por_ev)
            cause_q[`RTSEQ_CAUSE_POR_BIT] <= 1'b0;
         if (bor_ev && bor_en)
            cause_q[`RTSEQ_CAUSE_BOR_BIT] <= 1'b0;
      end
   end

   // flags decode reset kind; software cannot write them
   // pin reset while running leaves both flags as they were
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_q <= 1'b1;
         pd_q <= 1'b1;
      end else if (clk_en) begin
         if (por_ev || bor_ev) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
         end else if (wdt_run) begin
            to_q <= 1'b0;
            pd_q <= 1'b1;
         end else if (wdt_wake) begin
            to_q <= 1'b0;
            pd_q <= 1'b0;
         end else if (pin_slp || irq_wake_ev) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
         end else if (sleep_req_q && st_q == st_run) begin
            pd_q <= 1'b0;                                    // entering sleep
         end
      end
   end

   // ----------------------------------------
   // apb read path
   // ----------------------------------------
   // zero wait states: pready is tied high
   // status writes and unmapped addresses answer with pslverr
   always_comb begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = 1'b0;
      apb_rsp.prdata  = 32'h0;
      if (rd_en) begin
         case (apb_req.paddr)
            `RTSEQ_ADDR_CAUSE:  apb_rsp.prdata = {30'h0, cause_q};
            `RTSEQ_ADDR_STATUS: apb_rsp.prdata = {28'h0, core_sleeping, core_rst_q, to_q, pd_q};
            `RTSEQ_ADDR_CONFIG: apb_rsp.prdata = {26'h0, cfg_q};
            `RTSEQ_ADDR_CTRL:   apb_rsp.prdata = {31'h0, sleep_req_q};
            default:            apb_rsp.pslverr = apb_req.penable;
         endcase
      end else if (apb_req.psel && apb_req.pwrite) begin
         case (apb_req.paddr)
            `RTSEQ_ADDR_CAUSE, `RTSEQ_ADDR_CONFIG, `RTSEQ_ADDR_CTRL: apb_rsp.pslverr = 1'b0;
            default: apb_rsp.pslverr = apb_req.penable;
         endcase
      end
   end
endmodule // rtseq_top
`default_nettype wire

// File: verification/rtseq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// reset sequencer checker
// ----------
module rtseq_monitor (
   // clock and reset
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      clk_en,
   // bus and sources
   input wire rtseq_pkg::rtseq_apb_req_t apb_req,
   input wire rtseq_pkg::rtseq_apb_rsp_t apb_rsp,
   input wire rtseq_pkg::rtseq_src_t     src,
   input wire logic                      osc_input,
   // pin and core side
   input wire logic                      pin_io_in,
   input wire logic                      pin_drive_oe,
   input wire logic                      core_reset_n,
   input wire logic                      core_sleeping
);
   import rtseq_pkg::*;
   localparam int CPU_MIN = 600;
   logic [31:0] por_cnt_q;
   logic        quiet_io;
   // cycles since supply came good; saturates so a long run cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || !src.por_n) begin
         por_cnt_q <= 32'h0;
      end else if (por_cnt_q < 32'hffff) begin
         por_cnt_q <= por_cnt_q + 32'h1;
      end
   end
   // pin low in i/o mode with nothing else pending
   assign quiet_io = core_reset_n && !core_sleeping && !pin_io_in && src.por_n
                     && !src.below_bor && !src.watchdog_to;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_glitch;
      core_reset_n && $fell(src.ext_reset_n) ##2 src.ext_reset_n;
   endsequence
   sequence s_pin_low;
      (!src.ext_reset_n && pin_io_in) [*8] ##1 (!src.ext_reset_n && pin_io_in) [*6];
   endsequence
   property p_pin_oe; !pin_drive_oe; endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("reset pin driven");
   property p_glitch; s_glitch |-> core_reset_n [*8]; endproperty
   a_glitch: assert property (p_glitch) else $error("glitch reset core");
   property p_pin_low; s_pin_low |-> ##[0:8] !core_reset_n; endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin reset missed");
   property p_io; quiet_io [*4] |=> core_reset_n; endproperty
   a_io: assert property (p_io) else $error("i/o pin reset core");
   property p_por_hold; !src.por_n |-> ##[1:4] !core_reset_n; endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-on not held");
   property p_cpu; $rose(core_reset_n) |-> por_cnt_q >= CPU_MIN; endproperty
   a_cpu: assert property (p_cpu) else $error("cpu delay too short");
   property p_wd_reset;
      core_reset_n && !core_sleeping && src.watchdog_to |-> ##[1:5] !core_reset_n;
   endproperty
   a_wd_reset: assert property (p_wd_reset) else $error("watchdog no reset");
   property p_wd_wake; core_sleeping && src.watchdog_to |-> ##[1:5] !core_sleeping;
   endproperty
   a_wd_wake: assert property (p_wd_wake) else $error("watchdog no wake");
   property p_unmapped;
      apb_req.psel && apb_req.penable
      && !(apb_req.paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})
      |-> apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access");
endmodule // rtseq_monitor
bind rtseq_top rtseq_monitor u_monitor (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .src(src), .osc_input(osc_input), .pin_io_in(pin_io_in),
   .pin_drive_oe(pin_drive_oe), .core_reset_n(core_reset_n),
   .core_sleeping(core_sleeping));
`default_nettype wire

// File: verification/rtseq_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtseq_bench;
   import rtseq_pkg::*;
   // ----------
   // stimulus and observation
   // ----------
   localparam int PW = 1000; // kept above the cpu delay so the timer shows
   localparam rtseq_src_t IDLE = 5'h14;
   logic           pclk, presetn, clk_en, osc_input, osc_run, err;
   logic [1:0]     oc;
   logic [31:0]    rd;
   rtseq_apb_req_t req;
   rtseq_apb_rsp_t rsp;
   rtseq_src_t     src;
   logic           pin_io_in, pin_drive_oe, core_reset_n, core_sleeping;
   int             error_cnt, checked;
   rtseq_top #(.POWERUP_TIMER_CYC(PW), .BOR_CYC(20)) DUT (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
      .apb_rsp(rsp), .src(src), .osc_input(osc_input), .pin_io_in(pin_io_in),
      .pin_drive_oe(pin_drive_oe), .core_reset_n(core_reset_n),
      .core_sleeping(core_sleeping));
   // clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // crystal stand-in, period of eight bus clocks, only runs when asked
   always @(posedge pclk) begin
      oc <= oc + 2'h1;
      if (osc_run && oc == 2'h3) osc_input <= ~osc_input;
   end
   // hang guard, about twice the ~37k cycles the tests need
   initial begin
      #600000;
      error_cnt++;
      report_and_stop;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; waits for pready, then one idle cycle
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, output logic [31:0] v);
      xfer(1'b0, a, 32'h0);
      v = rd & m;
   endtask
   // bounded wait on core reset (sel 0) or sleep (sel 1)
   task automatic wait_for(input bit sel, input logic v, input int lim, output int n);
      n = 0;
      while ((sel ? core_sleeping : core_reset_n) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic t_power_on;
      int n;
      logic [31:0] v;
      wait_for(0, 1'b1, 20000, n);
      chk(n >= 620 && n < PW, 1);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h3);
      rdc(12'h000, 32'h2, v);
      chk(v, 32'h0);
      rdc(12'h008, 32'h3f, v);
      chk(v, 32'h3f);
      xfer(1'b1, 12'h004, 32'h0);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h3);
      xfer(1'b0, 12'h010, 32'h0);
      chk(err, 1);
      chk(rd, 0);
      xfer(1'b1, 12'h000, 32'h3);
      rdc(12'h000, 32'h3, v);
      chk(v, 32'h3);
      $display("power_on done");
   endtask
   task automatic t_pin;
      int n;
      logic seen;
      logic [31:0] v;
      seen = 1'b1;
      src.ext_reset_n <= 1'b0;
      cyc(2);
      src.ext_reset_n <= 1'b1;
      repeat (20) begin
         @(posedge pclk);
         seen &= core_reset_n;
      end
      chk(seen, 1);
      src.ext_reset_n <= 1'b0;
      cyc(40);
      chk(core_reset_n, 0);
      chk(pin_io_in, 1);
      src.ext_reset_n <= 1'b1;
      wait_for(0, 1'b1, 100, n);
      chk(n < 16, 1);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h3);
      $display("pin done");
   endtask
   task automatic t_io;
      logic seen;
      seen = 1'b1;
      xfer(1'b1, 12'h008, 32'h1f);
      src.ext_reset_n <= 1'b0;
      repeat (40) begin
         @(posedge pclk);
         seen &= core_reset_n;
      end
      chk(pin_io_in, 0);
      chk(seen, 1);
      src.ext_reset_n <= 1'b1;
      cyc(4);
      xfer(1'b1, 12'h008, 32'h3f);
      $display("io done");
   endtask
   task automatic t_wd;
      int n;
      logic [31:0] v;
      src.watchdog_to <= 1'b1;
      cyc(1);
      src.watchdog_to <= 1'b0;
      wait_for(0, 1'b0, 8, n);
      chk(n < 8, 1);
      chk(pin_drive_oe, 0);
      wait_for(0, 1'b1, 20000, n);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h1);
      rdc(12'h000, 32'h3, v);
      chk(v, 32'h3);
      $display("watchdog done");
   endtask
   // sleep, then wake by watchdog (0), interrupt (1) or pin (2)
   task automatic t_wake(input int k, input logic [31:0] e);
      int n;
      logic [31:0] v;
      xfer(1'b1, 12'h00c, 32'h1);
      cyc(2);
      chk(core_sleeping, 1);
      xfer(1'b1, 12'h00c, 32'h0);
      if (k == 0) src.watchdog_to <= 1'b1;
      else if (k == 1) src.irq_wake <= 1'b1;
      else src.ext_reset_n <= 1'b0;
      cyc(k == 2 ? 20 : 1);
      src <= IDLE;
      wait_for(1, 1'b0, 50, n);
      cyc(2);
      chk(core_reset_n, 0);
      wait_for(0, 1'b1, 20000, n);
      rdc(12'h004, 32'hf, v);
      chk(v, e);
      $display("wake done");
   endtask
   task automatic dip(input int n);
      src.below_bor <= 1'b1;
      cyc(n);
      src.below_bor <= 1'b0;
      cyc(1);
   endtask
   task automatic t_bor;
      int n;
      logic [31:0] v;
      dip(40);
      chk(core_reset_n, 0);
      wait_for(0, 1'b1, 20000, n);
      chk(n < PW, 1);
      rdc(12'h000, 32'h3, v);
      chk(v, 32'h2);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h3);
      xfer(1'b1, 12'h008, 32'h36);
      dip(40);
      cyc(500);
      dip(40);
      wait_for(0, 1'b1, 20000, n);
      chk(n >= PW, 1);
      xfer(1'b1, 12'h008, 32'h2e);
      dip(40);
      chk(core_reset_n, 1);
      xfer(1'b1, 12'h008, 32'h3f);
      $display("brownout done");
   endtask
   // interrupt wake per oscillator mode; crystal modes wait for 1024 edges
   task automatic t_osc(input logic [2:0] code);
      int n;
      xfer(1'b1, 12'h008, {26'h0, 3'h7, code});
      xfer(1'b1, 12'h00c, 32'h1);
      cyc(2);
      xfer(1'b1, 12'h00c, 32'h0);
      src.irq_wake <= 1'b1;
      cyc(1);
      src.irq_wake <= 1'b0;
      cyc(1500);
      chk(core_reset_n && !core_sleeping, code > 3'h2);
      osc_run <= 1'b1;
      wait_for(0, 1'b1, 12000, n);
      chk(n >= 8100, code < 3'h3);
      osc_run <= 1'b0;
      $display("osc done");
   endtask
   task automatic t_supply;
      int n;
      logic [31:0] v;
      xfer(1'b1, 12'h008, 32'h3f);
      src.por_n <= 1'b0;
      cyc(10);
      src.por_n <= 1'b1;
      wait_for(0, 1'b1, 20000, n);
      chk(n >= 620, 1);
      rdc(12'h000, 32'h2, v);
      chk(v, 32'h0);
      rdc(12'h004, 32'hf, v);
      chk(v, 32'h3);
      $display("supply done");
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      osc_input = 1'b0;
      osc_run = 1'b0;
      oc = 2'h0;
      req = '0;
      src = 5'h04;
      error_cnt = 0;
      checked = 0;
      cyc(4);
      presetn <= 1'b1;
      src <= IDLE;
      t_power_on;
      t_pin;
      t_io;
      t_wd;
      t_wake(0, 32'h0);
      t_wake(1, 32'h2);
      t_wake(2, 32'h2);
      t_bor;
      t_osc(3'h0);
      t_osc(3'h1);
      t_osc(3'h2);
      t_osc(3'h6);
      t_supply;
      report_and_stop;
   end
endmodule // rtseq_bench
`default_nettype wire
